// [design/asla_alu.v]
// add, subtract and bitwise-logic datapath with flag register
`timescale 1ns/100ps
`include "asla_regs.vh"
module asla_alu #(
  parameter CNT_W = 16 // width of the operation counters
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_reset,
  // request from the instruction decoder
  input wire i_op_valid,
  input wire [3:0] i_op_code,
  input wire i_dst_omitted,
  input wire [3:0] i_dst_idx,
  input wire [3:0] i_src1_idx,
  input wire [3:0] i_src2_idx,
  input wire i_use_imm,
  input wire [10:0] i_imm,
  input wire [31:0] i_src1_val,
  input wire [31:0] i_src2_val,
  // result toward the register file
  output reg o_res_valid,
  output reg [3:0] o_res_dst,
  output reg [31:0] o_res_data,
  output reg o_illegal,
  output reg [3:0] o_flags,
  // software register port
  input wire [7:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [31:0] o_reg_rdata
);

  // true when a register index names one of the eight low registers
  function is_low;
    input [3:0] idx;
    begin
      is_low = ~idx[3];
    end
  endfunction

  // true when an immediate is a multiple of four within a limit
  function imm_x4_ok;
    input [10:0] imm;
    input [10:0] lim;
    begin
      imm_x4_ok = (imm <= lim) && (imm[1:0] == 2'b00);
    end
  endfunction

  // state registers
  reg [3:0] flags_ff; // NZCV flags
  reg ctrl_check_ff; // operand checking enable
  reg [CNT_W-1:0] opcnt_ff; // executed operations
  reg [CNT_W-1:0] badcnt_ff; // refused operations
  reg [31:0] lastres_ff; // last written result

  // combinational datapath signals
  reg [3:0] eff_dst; // destination after omission rule
  reg [31:0] opnd_a; // adder first input
  reg [31:0] opnd_b; // adder second input, maybe inverted
  reg carry_in; // adder carry input
  reg [32:0] sum33; // 33-bit adder output
  reg [31:0] logic_res; // bitwise result
  reg [31:0] nxt_res; // selected result
  reg is_arith; // adder result selected
  reg sets_all; // updates N, Z, C and V
  reg sets_nz; // updates N and Z only
  reg legal; // operand form allowed
  reg known_op; // opcode belongs to this block
  reg [31:0] b_sel; // second operand before inversion
  reg ovf; // signed overflow
  reg [3:0] nxt_flags; // flags after this cycle

  // destination select
  always @* begin
    if (i_dst_omitted) begin
      eff_dst = i_src1_idx;
    end else begin
      eff_dst = i_dst_idx;
    end
  end

  // operand and carry steering for the shared adder
  always @* begin
    b_sel = i_use_imm ? {21'h000000, i_imm} : i_src2_val;
    opnd_a = i_src1_val;
    opnd_b = b_sel;
    carry_in = 1'b0;
    is_arith = 1'b1;
    case (i_op_code)
      `ASLA_OP_ADD, `ASLA_OP_ADDS: begin
        carry_in = 1'b0;
      end
      `ASLA_OP_ADD_WITH_CARRY_OP: begin
        opnd_b = i_src2_val;
        carry_in = flags_ff[`ASLA_FLAG_C];
      end
      `ASLA_OP_SUB, `ASLA_OP_MINUS_FLAGS_OP: begin
        // subtract as add of inverted operand plus one
        opnd_b = ~b_sel;
        carry_in = 1'b1;
      end
      `ASLA_OP_MINUS_WITH_BORROW_OP: begin
        // one extra taken off while the carry flag is set
        opnd_b = ~i_src2_val;
        carry_in = ~flags_ff[`ASLA_FLAG_C];
      end
      `ASLA_OP_NEGATE_OP: begin
        // zero minus first source gives the negation
        opnd_a = 32'h00000000;
        opnd_b = ~i_src1_val;
        carry_in = 1'b1;
      end
      default: begin
        is_arith = 1'b0;
      end
    endcase
  end

  // shared 33-bit adder, wraps modulo 2^32
  always @* begin
    sum33 = {1'b0, opnd_a} + {1'b0, opnd_b} + {32'h00000000, carry_in};
    // signed overflow: like-signed inputs, different result sign
    ovf = (opnd_a[31] == opnd_b[31]) && (sum33[31] != opnd_a[31]);
  end

  // bitwise unit; the register operand only, never an immediate
  always @* begin
    case (i_op_code)
      `ASLA_OP_AND: logic_res = i_src1_val & i_src2_val;
      `ASLA_OP_ORR: logic_res = i_src1_val | i_src2_val;
      `ASLA_OP_EOR: logic_res = i_src1_val ^ i_src2_val;
      `ASLA_OP_BIC: logic_res = i_src1_val & ~i_src2_val;
      default: logic_res = 32'h00000000;
    endcase
    nxt_res = is_arith ? sum33[31:0] : logic_res;
  end

  // which flags each operation touches
  always @* begin
    sets_all = 1'b0;
    sets_nz = 1'b0;
    known_op = 1'b1;
    case (i_op_code)
      `ASLA_OP_ADD, `ASLA_OP_SUB: begin
        sets_all = 1'b0; // flags kept
      end
      `ASLA_OP_ADDS, `ASLA_OP_ADD_WITH_CARRY_OP, `ASLA_OP_MINUS_FLAGS_OP,
      `ASLA_OP_MINUS_WITH_BORROW_OP, `ASLA_OP_NEGATE_OP: begin
        sets_all = 1'b1;
      end
      `ASLA_OP_AND, `ASLA_OP_ORR, `ASLA_OP_EOR, `ASLA_OP_BIC: begin
        sets_nz = 1'b1; // C and V left alone
      end
      default: begin
        // codes of the wider set handled by other units
        known_op = 1'b0;
      end
    endcase
  end

  // operand form checks; a form outside the allowed set is refused
  always @* begin
    legal = 1'b0;
    case (i_op_code)
      `ASLA_OP_ADD_WITH_CARRY_OP, `ASLA_OP_MINUS_WITH_BORROW_OP: begin
        legal = !i_use_imm && is_low(eff_dst) && is_low(i_src1_idx)
          && is_low(i_src2_idx) && (eff_dst == i_src1_idx);
      end
      `ASLA_OP_ADD: begin
        if (!i_use_imm) begin
          // any register except both sources the program counter, destination is first source
          legal = (eff_dst == i_src1_idx) &&
            !((i_src1_idx == `ASLA_IDX_PC) &&
              (i_src2_idx == `ASLA_IDX_PC));
        end else if ((eff_dst == `ASLA_IDX_SP) &&
                     (i_src1_idx == `ASLA_IDX_SP)) begin
          legal = imm_x4_ok(i_imm, `ASLA_IMM_SP_MAX);
        end else if (is_low(eff_dst) &&
                     ((i_src1_idx == `ASLA_IDX_SP) ||
                      (i_src1_idx == `ASLA_IDX_PC))) begin
          legal = imm_x4_ok(i_imm, `ASLA_IMM_PTR_MAX);
        end
      end
      `ASLA_OP_SUB: begin
        // only the stack pointer form exists for the plain subtract
        legal = i_use_imm && (eff_dst == `ASLA_IDX_SP) &&
          (i_src1_idx == `ASLA_IDX_SP) &&
          imm_x4_ok(i_imm, `ASLA_IMM_SP_MAX);
      end
      `ASLA_OP_ADDS, `ASLA_OP_MINUS_FLAGS_OP: begin
        if (!is_low(eff_dst) || !is_low(i_src1_idx)) begin
          legal = 1'b0;
        end else if (!i_use_imm) begin
          legal = is_low(i_src2_idx); // three-register form
        end else if (i_imm <= `ASLA_IMM_SMALL_MAX) begin
          legal = 1'b1; // three-operand small immediate
        end else begin
          legal = (i_imm <= `ASLA_IMM_BYTE_MAX) &&
            (eff_dst == i_src1_idx); // two-operand byte
        end
      end
      `ASLA_OP_NEGATE_OP: begin
        // the only immediate allowed is the zero itself
        legal = is_low(eff_dst) && is_low(i_src1_idx) &&
          (!i_use_imm || (i_imm == 11'h000));
      end
      `ASLA_OP_AND, `ASLA_OP_ORR, `ASLA_OP_EOR, `ASLA_OP_BIC: begin
        legal = !i_use_imm && is_low(eff_dst) &&
          is_low(i_src2_idx) && (eff_dst == i_src1_idx);
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    // checking off accepts any form of a known opcode; unknown codes stay refused
    if (!ctrl_check_ff && known_op) begin
      legal = 1'b1;
    end
  end

  // flag update; the flags an instruction sets beat a software write in one cycle
  always @* begin
    nxt_flags = flags_ff;
    if (i_reg_wr && (i_reg_addr == `ASLA_OFS_FLAGS)) begin
      nxt_flags = i_reg_wdata[3:0];
    end
    if (i_op_valid && legal && (sets_all || sets_nz)) begin
      nxt_flags[`ASLA_FLAG_N] = nxt_res[31];
      nxt_flags[`ASLA_FLAG_Z] = (nxt_res == 32'h00000000);
      if (sets_all) begin
        nxt_flags[`ASLA_FLAG_C] = sum33[32];
        nxt_flags[`ASLA_FLAG_V] = ovf;
      end
    end
  end

  // result, flags and counters
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      flags_ff <= `ASLA_FLAGS_RST;
      opcnt_ff <= {CNT_W{1'b0}};
      badcnt_ff <= {CNT_W{1'b0}};
      lastres_ff <= 32'h00000000;
      o_res_valid <= 1'b0;
      o_res_dst <= 4'h0;
      o_res_data <= 32'h00000000;
      o_illegal <= 1'b0;
      o_flags <= `ASLA_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
      o_flags <= nxt_flags;
      o_res_valid <= i_op_valid && legal;
      o_illegal <= i_op_valid && !legal;
      if (i_op_valid && legal) begin
        // write-back of the result
        o_res_dst <= eff_dst;
        o_res_data <= nxt_res;
        lastres_ff <= nxt_res;
        opcnt_ff <= opcnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (i_op_valid && !legal) begin
        // refused: nothing written, counter saturates at all ones
        if (badcnt_ff != {CNT_W{1'b1}}) begin
          badcnt_ff <= badcnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // control register write
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctrl_check_ff <= `ASLA_CTRL_RST;
    end else if (i_reg_wr && (i_reg_addr == `ASLA_OFS_CTRL)) begin
      ctrl_check_ff <= i_reg_wdata[`ASLA_CTRL_CHECK];
    end
  end

  // read port: data in the cycle after the strobe, zero otherwise
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `ASLA_OFS_FLAGS: o_reg_rdata <= {28'h0000000, flags_ff};
        `ASLA_OFS_CTRL: o_reg_rdata <= {31'h00000000, ctrl_check_ff};
        `ASLA_OFS_OPCNT:
          o_reg_rdata <= {{(32-CNT_W){1'b0}}, opcnt_ff};
        `ASLA_OFS_BADCNT:
          o_reg_rdata <= {{(32-CNT_W){1'b0}}, badcnt_ff};
        `ASLA_OFS_LASTRES: o_reg_rdata <= lastres_ff;
        default: o_reg_rdata <= 32'h00000000; // unmapped reads zero
      endcase
    end else begin
      o_reg_rdata <= 32'h00000000;
    end
  end

endmodule // asla_alu

// [pkg/asla_regs.vh]
// constants for the add/subtract/logic datapath block
// Function
// - datapath covers the listed data processing set
// - carry add: a plus b plus carry, flags
// - plain add: sum to destination, flags kept
// - flag add: same sum, update all flags
// - negate: zero minus first source, all flags
// - borrow subtract: a minus b minus carry
// - plain subtract: difference, flags kept
// - flag subtract: same difference, all flags
// - omitted destination means first source register
// - carry ops: low registers, destination equals source
// - plain register add: not both program counter
// - pointer plus immediate to low: 0-1020, x4
// - stack pointer add/sub immediate: 0-508, x4
// - flag add/sub: imm 0-7, 0-255, registers
// - logic ops: destination equals first operand
// - bit clear uses inverted b; logic sets N,Z
`ifndef ASLA_REGS_VH
`define ASLA_REGS_VH
// register map (word offsets, byte addresses)
`define ASLA_ADDR_W 8
`define ASLA_OFS_FLAGS 8'h00
`define ASLA_OFS_CTRL 8'h04
`define ASLA_OFS_OPCNT 8'h08
`define ASLA_OFS_BADCNT 8'h0c
`define ASLA_OFS_LASTRES 8'h10
// flag field positions in the flags register
`define ASLA_FLAG_V 0
`define ASLA_FLAG_C 1
`define ASLA_FLAG_Z 2
`define ASLA_FLAG_N 3
// control field positions and reset values
`define ASLA_CTRL_CHECK 0
`define ASLA_FLAGS_RST 4'h0
`define ASLA_CTRL_RST 1'b1
// operation codes from the decoder
`define ASLA_OP_ADD 4'h0
`define ASLA_OP_ADDS 4'h1
`define ASLA_OP_ADD_WITH_CARRY_OP 4'h2
`define ASLA_OP_SUB 4'h3
`define ASLA_OP_MINUS_FLAGS_OP 4'h4
`define ASLA_OP_MINUS_WITH_BORROW_OP 4'h5
`define ASLA_OP_NEGATE_OP 4'h6
`define ASLA_OP_AND 4'h7
`define ASLA_OP_ORR 4'h8
`define ASLA_OP_EOR 4'h9
`define ASLA_OP_BIC 4'ha
// special register indices
`define ASLA_IDX_SP 4'hd
`define ASLA_IDX_PC 4'hf
// immediate limits
`define ASLA_IMM_PTR_MAX 11'h3fc
`define ASLA_IMM_SP_MAX 11'h1fc
`define ASLA_IMM_SMALL_MAX 11'h007
`define ASLA_IMM_BYTE_MAX 11'h0ff
`endif

// [verif/add_sub_logic_alu_test.sv]
// self-checking bench for the add/subtract/logic datapath
`timescale 1ns/100ps
`include "asla_regs.vh"
module add_sub_logic_alu_test;
  localparam logic [10:0] no_imm = 11'h7ff; // marks register form
  logic clk = 1'b0, rst = 1'b1, ov = 1'b0, om = 1'b0, ui = 1'b0;
  logic wr = 1'b0, rd = 1'b0, rv, il;
  logic [3:0] oc = 4'h0, di = 4'h0, s1 = 4'h0, s2 = 4'h0, rdst, fl;
  logic [10:0] im = 11'h0;
  logic [7:0] ad = 8'h0;
  logic [31:0] a = 32'h0, b = 32'h0, wd = 32'h0, rdat, rdata, pv;
  int n_errors = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  asla_alu u_dut (.i_sys_clk(clk), .i_reset(rst), .i_op_valid(ov),
    .i_op_code(oc), .i_dst_omitted(om), .i_dst_idx(di), .i_src1_idx(s1),
    .i_src2_idx(s2), .i_use_imm(ui), .i_imm(im), .i_src1_val(a),
    .i_src2_val(b), .o_res_valid(rv), .o_res_dst(rdst), .o_res_data(rdat),
    .o_illegal(il), .o_flags(fl), .i_reg_addr(ad), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));
  asla_regfile u_rf (.i_sys_clk(clk), .i_res_valid(rv), .i_res_dst(rdst),
    .i_res_data(rdat), .i_rd_idx(di), .o_rd_val(pv));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one request pulse; answer sampled just after the taking edge
  task automatic op(input logic [3:0] c, input logic [12:0] ix,
    input logic [10:0] i, input logic [31:0] x, input logic [31:0] y);
    @(posedge clk);
    ov <= 1'b1;
    oc <= c;
    {om, di, s1, s2} <= ix;
    ui <= (i != no_imm);
    im <= i;
    a <= x;
    b <= y;
    @(posedge clk);
    ov <= 1'b0;
    #1;
  endtask
  // refused answers must leave flags as they were
  task automatic res(input logic ok, input logic [31:0] d,
    input logic [3:0] f);
    chk({30'h0, rv, il}, {30'h0, ok, !ok});
    if (ok) chk(rdat, d);
    chk({28'h0, fl}, {28'h0, f});
  endtask
  task automatic wreg(input logic [7:0] x, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    ad <= x;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] x, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    ad <= x;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic t_arith;
    rreg(`ASLA_OFS_FLAGS, 32'h0);
    rreg(`ASLA_OFS_CTRL, 32'h1);
    rreg(8'h40, 32'h0);
    op(`ASLA_OP_ADDS, 13'h002, no_imm, 32'hffffffff, 32'h1);
    res(1, 32'h0, 4'h6);
    op(4'h2, 13'h113, no_imm, 32'h1, 32'h2);
    res(1, 32'h4, 4'h0);
    @(posedge clk);
    #1;
    chk(pv, 32'h4);
    op(4'h4, 13'h123, no_imm, 32'h5, 32'h7);
    res(1, 32'hfffffffe, 4'h8);
    op(4'h4, 13'h110, 11'd1, 32'h80000000, 32'h0);
    res(1, 32'h7fffffff, 4'h3);
    op(`ASLA_OP_ADD, 13'h881, no_imm, 32'h5, 32'h7);
    res(1, 32'hc, 4'h3);
    op(4'h5, 13'h112, no_imm, 32'ha, 32'h3);
    res(1, 32'h6, 4'h2);
    op(4'h6, 13'h120, no_imm, 32'h1, 32'h0);
    res(1, 32'hffffffff, 4'h8);
    op(4'h6, 13'h120, no_imm, 32'h0, 32'h0);
    res(1, 32'h0, 4'h6);
  endtask
  task automatic t_forms;
    op(`ASLA_OP_SUB, 13'hdd0, 11'd508, 32'd1000, 32'h0);
    res(1, 32'h1ec, 4'h6);
    op(`ASLA_OP_SUB, 13'hdd0, 11'd510, 32'd1000, 32'h0);
    res(0, 32'h0, 4'h6);
    op(`ASLA_OP_ADD, 13'h2d0, 11'd1020, 32'h100, 32'h0);
    res(1, 32'h4fc, 4'h6);
    op(`ASLA_OP_ADD, 13'h2f0, 11'd1024, 32'h100, 32'h0);
    res(0, 32'h0, 4'h6);
    op(`ASLA_OP_ADD, 13'hfff, no_imm, 32'h1, 32'h1);
    res(0, 32'h0, 4'h6);
    op(4'h2, 13'h118, no_imm, 32'h1, 32'h1);
    res(0, 32'h0, 4'h6);
    op(`ASLA_OP_ADDS, 13'h120, 11'd8, 32'h1, 32'h0);
    res(0, 32'h0, 4'h6);
    op(`ASLA_OP_ADDS, 13'h220, 11'd255, 32'h1, 32'h0);
    res(1, 32'h100, 4'h0);
    op(4'hb, 13'h110, no_imm, 32'h0, 32'h0);
    res(0, 32'h0, 4'h0);
    op(`ASLA_OP_ADDS, 13'h1734, no_imm, 32'h1, 32'h1);
    res(1, 32'h2, 4'h0);
    chk({28'h0, rdst}, 32'h3);
  endtask
  // carry and overflow preset so the logic ops show they keep them
  task automatic t_logic;
    logic [31:0] e;
    wreg(`ASLA_OFS_FLAGS, 32'h3);
    // operands differ so a swapped opcode shows in the result
    for (int k = 0; k < 4; k++) begin
      op(4'(`ASLA_OP_AND + k), 13'h334, no_imm, 32'h800000f0, 32'h8000fff0);
      case (k)
        0: e = 32'h800000f0;
        1: e = 32'h8000fff0;
        2: e = 32'h0000ff00;
        default: e = 32'h00000000;
      endcase
      res(1, e, {e[31], e == 32'h0, 2'b11});
    end
    op(`ASLA_OP_AND, 13'h324, no_imm, 32'h1, 32'h1);
    res(0, 32'h0, 4'h7);
  endtask
  // counters, last result and the checking switch
  task automatic t_regs;
    rreg(`ASLA_OFS_OPCNT, 32'h10);
    rreg(`ASLA_OFS_BADCNT, 32'h7);
    op(`ASLA_OP_ADD, 13'h212, no_imm, 32'h5, 32'h6);
    res(0, 32'h0, 4'h7);
    wreg(`ASLA_OFS_CTRL, 32'h0);
    op(`ASLA_OP_ADD, 13'h212, no_imm, 32'h5, 32'h6);
    res(1, 32'hb, 4'h7);
    rreg(`ASLA_OFS_LASTRES, 32'hb);
    wreg(`ASLA_OFS_CTRL, 32'h1);
    rreg(`ASLA_OFS_CTRL, 32'h1);
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_arith;
    t_forms;
    t_logic;
    t_regs;
    finish_test;
  end
endmodule // add_sub_logic_alu_test

// [verif/asla_alu_properties.sv]
// assertion checker for the add/subtract/logic datapath
`timescale 1ns/100ps
`include "asla_regs.vh"
module asla_alu_chk (
  // clock, reset and request
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_op_valid,
  input wire [3:0] i_op_code,
  input wire i_dst_omitted,
  input wire [3:0] i_src1_idx,
  input wire [3:0] i_src2_idx,
  input wire i_use_imm,
  input wire [10:0] i_imm,
  input wire [31:0] i_src1_val,
  input wire [31:0] i_src2_val,
  input wire i_reg_wr,
  // answer
  input wire o_res_valid,
  input wire [3:0] o_res_dst,
  input wire [31:0] o_res_data,
  input wire o_illegal,
  input wire [3:0] o_flags
);
  // 33-bit sum of the request, carry in bit 32
  logic [32:0] sum_ff;
  always_ff @(posedge i_sys_clk) begin
    sum_ff <= {1'b0, i_src1_val} +
      (i_use_imm ? {22'h0, i_imm} : {1'b0, i_src2_val});
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  property p_answer; i_op_valid |=> o_res_valid != o_illegal; endproperty
  a_answer: assert property (p_answer) else $error("answer count");
  property p_quiet; !i_op_valid |=> !o_res_valid && !o_illegal; endproperty
  a_quiet: assert property (p_quiet) else $error("answer unasked");
  property p_keep;
    i_op_valid && !i_reg_wr && (i_op_code == `ASLA_OP_ADD ||
      i_op_code == `ASLA_OP_SUB) |=> $stable(o_flags);
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_sum;
    i_op_valid && i_op_code == `ASLA_OP_ADDS |=>
      o_illegal || {o_flags[1], o_res_data} == sum_ff;
  endproperty
  a_sum: assert property (p_sum) else $error("sum or carry");
  property p_nz;
    o_res_valid && $past(i_op_code) != `ASLA_OP_ADD && !$past(i_reg_wr) &&
      $past(i_op_code) != `ASLA_OP_SUB |->
      o_flags[3:2] == {o_res_data[31], o_res_data == 32'h0};
  endproperty
  a_nz: assert property (p_nz) else $error("n or z flag");
  property p_logic;
    i_op_valid && !i_reg_wr && i_op_code >= `ASLA_OP_AND &&
      i_op_code <= `ASLA_OP_BIC |=> $stable(o_flags[1:0]);
  endproperty
  a_logic: assert property (p_logic) else $error("c or v moved");
  property p_neg;
    i_op_valid && i_op_code == 4'h6 |=>
      o_illegal || o_res_data == 32'h0 - $past(i_src1_val);
  endproperty
  a_neg: assert property (p_neg) else $error("negate value");
  property p_dst;
    i_op_valid && i_dst_omitted |=>
      o_illegal || o_res_dst == $past(i_src1_idx);
  endproperty
  a_dst: assert property (p_dst) else $error("omitted dest");
  property p_pc;
    i_op_valid && i_op_code == `ASLA_OP_ADD && !i_use_imm &&
      i_src1_idx == `ASLA_IDX_PC && i_src2_idx == `ASLA_IDX_PC |=> o_illegal;
  endproperty
  a_pc: assert property (p_pc) else $error("pc pair taken");
  property p_low;
    i_op_valid && (i_op_code == 4'h2 || i_op_code == 4'h5) &&
      (i_src1_idx[3] || i_src2_idx[3]) |=> o_illegal;
  endproperty
  a_low: assert property (p_low) else $error("high reg taken");
  // main scenarios seen
  c_carry: cover property (i_op_valid && i_op_code == 4'h2 ##1 o_res_valid);
  c_bad: cover property (o_illegal);
  c_neg: cover property (i_op_valid && i_op_code == 4'h6 ##1 o_res_valid);
endmodule // asla_alu_chk
bind asla_alu asla_alu_chk u_chk (.i_sys_clk, .i_reset, .i_op_valid,
  .i_op_code, .i_dst_omitted, .i_src1_idx, .i_src2_idx, .i_use_imm, .i_imm,
  .i_src1_val, .i_src2_val, .i_reg_wr, .o_res_valid, .o_res_dst,
  .o_res_data, .o_illegal, .o_flags);

// [verif/asla_regfile.sv]
// register file model taking the datapath's results
`timescale 1ns/100ps
module asla_regfile (
  // results in
  input wire i_sys_clk,
  input wire i_res_valid,
  input wire [3:0] i_res_dst,
  input wire [31:0] i_res_data,
  // readback
  input wire [3:0] i_rd_idx,
  output logic [31:0] o_rd_val
);
  // sixteen words, cleared so a missed write shows
  logic [31:0] mem_ff [16] = '{default: 32'h0};
  always @(posedge i_sys_clk) begin
    if (i_res_valid) mem_ff[i_res_dst] <= i_res_data;
  end
  assign o_rd_val = mem_ff[i_rd_idx];
endmodule // asla_regfile
